// >>> verilog/urx_recovery.sv
// receiver data recovery with Avalon-MM register slave
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "urx_defines.svh"
module urx_recovery #(
   parameter int DIVISOR_RESET = `URX_CLK_HZ / (`URX_BAUD_RESET_RATE * `URX_OVERSAMPLE)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic serialInputPin,
   output logic rxIrq
);
   import urx_pkg::*;

   // ----------------------------------------
   // registers and pin synchroniser
   // ----------------------------------------
   urx_rx_t rx, next_rx;
   urx_flags_t flags, next_flags;
   urx_ctrl_t ctrl, next_ctrl;
   logic [15:0] divisor, next_divisor;
   logic [15:0] divCnt, next_divCnt;
   logic [7:0] dataBuf, next_dataBuf;
   logic ninthBit, next_ninthBit;
   logic ackQ, next_ackQ;
   logic [31:0] next_readdata;
   logic pinMeta, pin;
   logic tick, done, stopBad, isBreak, accept, startSeen;
   logic voteBit, disagree;
   logic [1:0] startHighs;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pinMeta <= 1'b1;
         pin <= 1'b1;
      end
      else
      begin
         pinMeta <= serialInputPin;
         pin <= pinMeta;
      end
   end

   // ----------------------------------------
   // oversample tick at sixteen per bit
   // ----------------------------------------
   always_comb
   begin
      tick = (divCnt >= divisor - 16'h0001);
      next_divCnt = tick ? 16'h0000 : divCnt + 16'h0001;
   end

   // ----------------------------------------
   // sample votes
   // ----------------------------------------
   always_comb
   begin
      voteBit = (rx.votes[0] & rx.votes[1]) | (rx.votes[0] & pin) | (rx.votes[1] & pin);
      disagree = !((rx.votes == 2'b11 && pin) || (rx.votes == 2'b00 && !pin));
      startHighs = 2'(rx.votes[0]) + 2'(rx.votes[1]) + 2'(pin);
   end

   // ----------------------------------------
   // recovery state machine
   // ----------------------------------------
   always_comb
   begin
      next_rx = rx;
      done = 1'b0;
      stopBad = 1'b0;
      startSeen = 1'b0;
      if (!ctrl.enable)
      begin
         next_rx = '0;
         next_rx.prevPin = 1'b1;
      end
      else if (tick)
      begin
         next_rx.prevPin = pin;
         unique case (rx.state)
            URX_IDLE:
            begin
               next_rx.hist = {rx.hist[1:0], pin};
               if (rx.hist == 3'h7 && !pin)
               begin
                  startSeen = 1'b1;
                  next_rx.state = URX_START;
                  next_rx.rt = 5'h01;
                  next_rx.bitIdx = 4'h0;
                  next_rx.shift = 9'h000;
                  next_rx.noise = 1'b0;
                  next_rx.lastOne = 1'b0;
               end
            end
            URX_START, URX_DATA, URX_STOP:
            begin
               next_rx.rt = (rx.rt == `URX_RT_LAST) ? 5'h01 : rx.rt + 5'h01;
               if (rx.rt == `URX_RT_START_A || rx.rt == `URX_RT_BIT_A)
                  next_rx.votes[0] = pin;
               if (rx.rt == `URX_RT_START_B || rx.rt == `URX_RT_BIT_B)
                  next_rx.votes[1] = pin;
               if (rx.state == URX_START && rx.rt == `URX_RT_START_C)
               begin
                  if (startHighs >= 2'h2)
                  begin
                     next_rx = '0;
                     next_rx.prevPin = pin;
                  end
                  else if (startHighs == 2'h1)
                     next_rx.noise = 1'b1;
               end
               if (rx.rt == `URX_RT_BIT_C)
               begin
                  if (rx.state == URX_START)
                  begin
                     if (rx.votes != 2'b00 || pin)
                        next_rx.noise = 1'b1;
                     next_rx.state = URX_DATA;
                  end
                  else if (rx.state == URX_DATA)
                  begin
                     next_rx.shift[rx.bitIdx] = voteBit;
                     next_rx.noise = rx.noise | disagree;
                     next_rx.lastOne = voteBit;
                     next_rx.bitIdx = rx.bitIdx + 4'h1;
                     if (rx.bitIdx == (ctrl.len9 ? 4'h8 : 4'h7))
                        next_rx.state = URX_STOP;
                  end
                  else
                  begin
                     done = 1'b1;
                     stopBad = !voteBit;
                     next_rx.noise = rx.noise | disagree;
                     next_rx.state = URX_IDLE;
                     next_rx.hist = 3'h0;
                     next_rx.lastOne = 1'b0;
                  end
               end
               // realign on a falling edge after a bit that voted high
               if (rx.state != URX_START && rx.lastOne && rx.prevPin && !pin &&
                  (rx.rt < `URX_RT_BIT_A || rx.rt > `URX_RT_BIT_C))
               begin
                  next_rx.rt = 5'h01;
                  next_rx.lastOne = 1'b0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // buffer and flags
   // ----------------------------------------
   always_comb
   begin
      accept = (avs_read | avs_write) & ackQ;
      isBreak = stopBad && rx.shift == 9'h000;
      next_flags = flags;
      next_dataBuf = dataBuf;
      next_ninthBit = ninthBit;
      if (accept && avs_read && avs_address == `URX_ADDR_DATA)
         next_flags = '0;
      if (done)
      begin
         if (flags.full)
            next_flags.overrun = 1'b1;
         else
         begin
            next_dataBuf = isBreak ? 8'h00 : rx.shift[7:0];
            next_ninthBit = isBreak ? 1'b0 : (ctrl.len9 ? rx.shift[8] : rx.shift[7]);
            next_flags.full = 1'b1;
            next_flags.framing = stopBad;
            next_flags.noise = rx.noise | disagree;
            next_flags.brk = isBreak;
         end
      end
   end

   assign rxIrq = flags.full & ctrl.irqEn;

   // ----------------------------------------
   // Avalon-MM slave, one wait state
   // ----------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & !ackQ;

   always_comb
   begin
      next_ackQ = (avs_read | avs_write) & !ackQ;
      next_ctrl = ctrl;
      next_divisor = divisor;
      next_readdata = avs_readdata;
      if (accept && avs_write)
      begin
         if (avs_address == `URX_ADDR_CONTROL)
            next_ctrl = avs_writedata[2:0];
         if (avs_address == `URX_ADDR_BAUD && avs_writedata[15:0] != 16'h0000)
            next_divisor = avs_writedata[15:0];
      end
      if (avs_read && !ackQ)
      begin
         next_readdata = 32'h00000000;
         unique case (avs_address)
            `URX_ADDR_DATA:
            begin
               next_readdata[7:0] = dataBuf;
               next_readdata[`URX_DATA_NINTH] = ninthBit;
            end
            `URX_ADDR_STATUS:
            begin
               next_readdata[4:0] = {flags.brk, flags.framing, flags.noise, flags.overrun,
                  flags.full};
               next_readdata[`URX_ST_BUSY] = (rx.state != URX_IDLE);
            end
            `URX_ADDR_CONTROL:
               next_readdata[2:0] = ctrl;
            `URX_ADDR_BAUD:
               next_readdata[15:0] = divisor;
            default:
               next_readdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rx <= '0;
         flags <= '0;
         ctrl <= `URX_CONTROL_RESET;
         divisor <= 16'(DIVISOR_RESET);
         divCnt <= 16'h0000;
         dataBuf <= 8'h00;
         ninthBit <= 1'b0;
         ackQ <= 1'b0;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         rx <= next_rx;
         flags <= next_flags;
         ctrl <= next_ctrl;
         divisor <= next_divisor;
         divCnt <= next_divCnt;
         dataBuf <= next_dataBuf;
         ninthBit <= next_ninthBit;
         ackQ <= next_ackQ;
         avs_readdata <= next_readdata;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   irq_raise_a: assert property (@(posedge clk) disable iff (reset)
      done && !flags.full && ctrl.irqEn |=> rxIrq)
      else $error("interrupt not raised on receiver full");
   start_reject_a: assert property (@(posedge clk) disable iff (reset)
      tick && ctrl.enable && rx.state == URX_START && rx.rt == `URX_RT_START_C &&
      startHighs >= 2'h2 |=> rx.state == URX_IDLE && rx.rt == 5'h00)
      else $error("bad start bit not rejected");
   start_align_a: assert property (@(posedge clk) disable iff (reset)
      startSeen |=> rx.state == URX_START && rx.rt == 5'h01)
      else $error("start edge did not restart tick count");
   frame_same_a: assert property (@(posedge clk) disable iff (reset)
      done && !flags.full |=> flags.full && flags.framing == $past(stopBad))
      else $error("framing flag not set with receiver full");
   overrun_keep_a: assert property (@(posedge clk) disable iff (reset)
      done && flags.full |=> flags.overrun && $stable(dataBuf))
      else $error("overrun lost old data");
   break_clear_a: assert property (@(posedge clk) disable iff (reset)
      done && !flags.full && isBreak |=> dataBuf == 8'h00 && !ninthBit && flags.brk)
      else $error("break did not clear buffer");
   buffer_ro_a: assert property (@(posedge clk) disable iff (reset)
      avs_write && !done |=> $stable(dataBuf))
      else $error("bus write changed data buffer");
   rt_hold_a: assert property (@(posedge clk) disable iff (reset)
      !tick && ctrl.enable && rx.state != URX_IDLE |=> $stable(rx.rt))
      else $error("tick count moved without a tick");
   bus_answer_a: assert property (@(posedge clk) disable iff (reset)
      avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered after one wait state");
   realign_edge_a: assert property (@(posedge clk) disable iff (reset)
      tick && ctrl.enable && rx.state == URX_DATA && rx.lastOne && rx.prevPin && !pin &&
      (rx.rt < `URX_RT_BIT_A || rx.rt > `URX_RT_BIT_C) |=> rx.rt == 5'h01)
      else $error("tick count not realigned on falling edge");
   hunt_wait_a: assert property (@(posedge clk) disable iff (reset)
      tick && rx.state == URX_IDLE && rx.hist != 3'h7 |=> rx.state == URX_IDLE)
      else $error("start taken without three high samples");
   len_stop_a: assert property (@(posedge clk) disable iff (reset)
      tick && ctrl.enable && rx.state == URX_DATA && rx.rt == `URX_RT_BIT_C &&
      rx.bitIdx == (ctrl.len9 ? 4'h8 : 4'h7) |=> rx.state == URX_STOP)
      else $error("stop bit not reached after last data bit");
   stop_end_a: assert property (@(posedge clk) disable iff (reset)
      tick && ctrl.enable && rx.state == URX_STOP && rx.rt == `URX_RT_BIT_C |-> done)
      else $error("character not completed at stop sample");
   full_hold_a: assert property (@(posedge clk) disable iff (reset)
      flags.full && !(accept && avs_read && avs_address == `URX_ADDR_DATA) |=> flags.full)
      else $error("receiver full dropped without a data read");
   noise_show_a: assert property (@(posedge clk) disable iff (reset)
      done && !flags.full |=> flags.noise == $past(rx.noise || disagree))
      else $error("noise of character not shown on transfer");
endmodule

// >>> shared/urx_defines.svh
// constants for the receiver data-recovery block
// Behaviour
// - completed character moves into data buffer and sets receiver full flag
// - data buffer is read-only from the bus; holds last character
// - receiver full with irq enable raises the receiver interrupt
// - pin sampled on a tick at sixteen times the baud rate
// - tick counter realigned on every start edge
// - tick counter realigned on a 1 bit followed by a 0 bit
// - start hunt looks for low after three high samples
// - candidate start edge starts counting sixteen ticks per bit
// - start checked at ticks 3,5,7; one high is noise, two reject
// - rejected start resets the counter and restarts the hunt
// - data bit is majority of ticks 8,9,10; disagreement is noise
// - start samples 8-10 never reject; any high there is noise
// - stop majority low sets framing error; disagreement is noise
// - missing stop high, break included, sets framing error
// - framing error appears in the same cycle as receiver full
// - a falling edge after a 1 bit realigns the counter, except in the start bit or at ticks 8-10
// - stop sampling ends 9 or 10 bit periods plus ten ticks after start
// - 8 or 9 data bits; ninth holder copies bit 7 in 8-bit mode
// - break sets framing, full and break flags; clears buffer, ninth bit
// - character done while full sets overrun, old data kept, new lost
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH
`define URX_ADDR_DATA 4'h0
`define URX_ADDR_STATUS 4'h4
`define URX_ADDR_CONTROL 4'h8
`define URX_ADDR_BAUD 4'hC
`define URX_ST_FULL 0
`define URX_ST_OVERRUN 1
`define URX_ST_NOISE 2
`define URX_ST_FRAMING 3
`define URX_ST_BREAK 4
`define URX_ST_BUSY 5
`define URX_CT_ENABLE 0
`define URX_CT_LEN9 1
`define URX_CT_IRQEN 2
`define URX_DATA_NINTH 8
`define URX_CONTROL_RESET 3'h0
`define URX_CLK_HZ 50000000
`define URX_BAUD_RESET_RATE 9600
`define URX_OVERSAMPLE 16
`define URX_RT_LAST 5'h10
`define URX_RT_START_A 5'h03
`define URX_RT_START_B 5'h05
`define URX_RT_START_C 5'h07
`define URX_RT_BIT_A 5'h08
`define URX_RT_BIT_B 5'h09
`define URX_RT_BIT_C 5'h0A
`endif

// >>> shared/urx_pkg.sv
// types of the receiver data-recovery block
package urx_pkg;
   typedef enum logic [1:0] {
      URX_IDLE = 2'b00,
      URX_START = 2'b01,
      URX_DATA = 2'b10,
      URX_STOP = 2'b11
   } urx_state_t;
   typedef struct packed {
      urx_state_t state;
      logic [4:0] rt;
      logic [3:0] bitIdx;
      logic [1:0] votes;
      logic [2:0] hist;
      logic [8:0] shift;
      logic noise;
      logic lastOne;
      logic prevPin;
   } urx_rx_t;
   typedef struct packed {
      logic brk;
      logic framing;
      logic noise;
      logic overrun;
      logic full;
   } urx_flags_t;
   typedef struct packed {
      logic irqEn;
      logic len9;
      logic enable;
   } urx_ctrl_t;
endpackage

// >>> sim/urx_tx_model.sv
// far-side serial transmitter model
`timescale 1ns/10ps
module urx_tx_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [8:0] data,
   input wire logic len9,
   input wire logic stopBit,
   input wire logic [7:0] bitClks,
   input wire logic [7:0] gA,
   input wire logic [7:0] gB,
   output logic pin = 1'b1,
   output logic busy = 1'b0
);
   // ----------------------------------------
   // frame sender
   // ----------------------------------------
   task automatic hold(input logic v);
      pin <= v;
      repeat (bitClks) @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      if (go)
      begin
         busy <= 1'b1;
         // low start, high spike in [gA,gB); gB of FF aborts the frame
         for (int i = 0; i < bitClks; i++)
         begin
            pin <= (i >= gA && i < gB);
            @(posedge clk);
         end
         if (gB != 8'hFF)
         begin
            for (int b = 0; b < (len9 ? 9 : 8); b++)
               hold(data[b]);
            hold(stopBit);
         end
         repeat (3) hold(1'b1);
         busy <= 1'b0;
      end
   end
endmodule

// >>> sim/tb_urx_recovery.sv
// self-checking bench for the receiver data-recovery block
`timescale 1ns/10ps
module tb_urx_recovery;
   logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, pin, rxIrq, busy;
   logic go = 1'b0, len9 = 1'b0, stopBit = 1'b1;
   logic [8:0] data = 9'h0;
   logic [7:0] bitClks = 8'h40, gA = 8'h0, gB = 8'h0;
   int bad_count = 0;
   int compares = 0;
   always #10 clk = ~clk;
   urx_recovery uut (.clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .serialInputPin(pin), .rxIrq);
   urx_tx_model far (.clk, .go, .data, .len9, .stopBit, .bitClks, .gA, .gB,
      .pin, .busy);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task tally_and_finish;
      $display("compares %0d errors %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("ERROR %s exp %h seen %h", nm, e, s);
      end
   endtask
   // request held until waitrequest is sampled low
   task bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
      begin
         n++;
         if (n > 20)
         begin
            bad_count++;
            tally_and_finish;
         end
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task rdc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk($sformatf("reg%h", a), x, e);
   endtask
   // one frame with its idle gap; g holds spike start and end
   task send(input logic [8:0] d, input logic s, input logic [7:0] b, input logic [15:0] g);
      int n;
      n = 0;
      @(posedge clk);
      data <= d;
      stopBit <= s;
      bitClks <= b;
      gA <= g[15:8];
      gB <= g[7:0];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1 && n < 1500)
      begin
         n++;
         @(posedge clk);
      end
      if (n >= 1500)
      begin
         bad_count++;
         tally_and_finish;
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rdc(4'h4, 32'h0);
      rdc(4'h8, 32'h0);
      rdc(4'hC, 32'h145);
      rdc(4'h2, 32'h0);
      wr(4'hC, 32'h4);
      rdc(4'hC, 32'h4);
      wr(4'hC, 32'h0);
      rdc(4'hC, 32'h4);
      wr(4'h8, 32'h5);
      rdc(4'h8, 32'h5);
      // hunter needs three high ticks before the first start edge
      repeat (20) @(posedge clk);
      send(9'h0A5, 1'b1, 8'h40, 16'h0);
      chk("irq", {31'h0, rxIrq}, 32'h1);
      rdc(4'h4, 32'h1);
      rdc(4'h0, 32'h1A5);
      @(posedge clk);
      chk("irq", {31'h0, rxIrq}, 32'h0);
      wr(4'h0, 32'h55);
      rdc(4'h0, 32'h1A5);
      rdc(4'h4, 32'h0);
      wr(4'h8, 32'h1);
      send(9'h03C, 1'b0, 8'h40, 16'h0);
      chk("irq", {31'h0, rxIrq}, 32'h0);
      rdc(4'h4, 32'h9);
      rdc(4'h0, 32'h03C);
      send(9'h000, 1'b0, 8'h40, 16'h0);
      rdc(4'h4, 32'h19);
      rdc(4'h0, 32'h0);
      send(9'h000, 1'b1, 8'h40, 16'h08FF);
      rdc(4'h4, 32'h0);
      send(9'h096, 1'b1, 8'h40, 16'h0);
      rdc(4'h4, 32'h1);
      rdc(4'h0, 32'h196);
      send(9'h05A, 1'b1, 8'h40, 16'h1018);
      rdc(4'h4, 32'h5);
      rdc(4'h0, 32'h05A);
      send(9'h0C3, 1'b1, 8'h40, 16'h2428);
      rdc(4'h4, 32'h5);
      rdc(4'h0, 32'h1C3);
      send(9'h055, 1'b1, 8'h3A, 16'h0);
      send(9'h0AA, 1'b1, 8'h42, 16'h0);
      rdc(4'h4, 32'h3);
      rdc(4'h0, 32'h055);
      wr(4'h8, 32'h3);
      len9 <= 1'b1;
      send(9'h12B, 1'b1, 8'h40, 16'h0);
      rdc(4'h4, 32'h1);
      rdc(4'h0, 32'h12B);
      tally_and_finish;
   end
endmodule
